// ---- common/utxf_pkg.sv ----
package utxf_pkg;

  // FIFO fill state encoding.
  localparam logic [1:0] FILL_EMPTY = 2'h0;
  localparam logic [1:0] FILL_ONE_A = 2'h1;
  localparam logic [1:0] FILL_ONE_B = 2'h2;
  localparam logic [1:0] FILL_TWO   = 2'h3;
  localparam logic [1:0] FILL_RESET = FILL_EMPTY;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CLEAR  = 12'h008;
  localparam logic [11:0] OFS_COUNT  = 12'h00C;

  // Control register bit positions.
  localparam int CTRL_EPEN  = 0;
  localparam int CTRL_ATM   = 1;
  localparam int CTRL_OE    = 2;
  localparam int CTRL_ISO   = 3;
  localparam int CTRL_STALL = 4;
  localparam int CTRL_CTLEP = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Status register bit positions; flags also used in the clear register.
  localparam int ST_ERR  = 0;
  localparam int ST_ACK  = 1;
  localparam int ST_VOID = 2;
  localparam int ST_OVF  = 3;
  localparam int ST_URF  = 4;
  localparam int ST_SOF  = 5;
  localparam int ST_FILL = 8;

  localparam int COUNT_W = 10;

  // Answer given to an IN token.
  typedef enum logic [1:0] {
    RESP_NONE = 2'b00,
    RESP_NAK  = 2'b01,
    RESP_DATA = 2'b10,
    RESP_NULL = 2'b11
  } utxf_resp_e;

  // Events reported by the serial interface engine.
  typedef struct packed {
    logic in_token;
    logic sent_ack;
    logic sent_timeout;
    logic sent_underrun;
    logic sof;
    logic setup_rcvd;
  } utxf_sie_s;

  typedef struct packed {
    logic err;
    logic ack;
    logic void_f;
    logic ovf;
    logic urf;
  } utxf_flags_s;

endpackage : utxf_pkg

// ---- verilog/utxf_endpoint.sv ----
// Operation
// - Empty FIFO or output disabled: IN gets NAK, void set, stays empty.
// - Control endpoint with setup flag set NAKs IN even if stalled; void set.
// - After such a NAK on loaded FIFO, keep NAKing IN until cleared.
// - Byte-count write advances fill: empty to one packet, one to two.
// - Byte-count write while two packets held sets sticky overrun.
// - Load overrun sets overrun, keeps fill, NAKs later non-iso IN.
// - Non-iso ACKed send: drop packet, set ack, clear err/void, interrupt.
// - Non-iso timeout: keep fill, set error, clear ack, interrupt.
// - Non-iso underrun: set error and underrun, interrupt, NAK later.
// - IN with underrun and error set: NAK, set void, nothing else.
// - Retransmit after timeout that is ACKed sets ack, clears error, drops.
// - Iso IN with empty FIFO or output disabled: null packet, void set.
// - Iso with output disabled and data loaded answers null, never NAK.
// - Iso send: no handshake, advance marker, set ack, no interrupt.
// - Iso underrun: error and underrun set, marker still advances.
// - Iso: count write at once; fill decrement and underrun at frame start.
// - Iso error, ack and void update at each transaction end.
// - All of this only while endpoint enable and auto management active.
// - Iso frame start with unread packet flushes oldest, sets frame flag.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
module utxf_endpoint (
  // APB slave
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Serial interface engine events, same clock
  input  wire utxf_pkg::utxf_sie_s          sie_evt,
  output utxf_pkg::utxf_resp_e              in_resp,
  output logic                              rd_slot,
  // Status outputs
  output logic                              tx_irq,
  output logic [1:0]                        tx_fifo_fill_state
);

  logic [5:0]                   ctrl;
  utxf_pkg::utxf_flags_s        flg;
  logic                         sof_flag;
  logic                         nak_lock;
  logic                         pend_dec;
  logic                         pend_urf;
  logic [utxf_pkg::COUNT_W-1:0] tx_byte_count;

  wire tx_endpoint_enable = ctrl[utxf_pkg::CTRL_EPEN];
  wire auto_tx_management = ctrl[utxf_pkg::CTRL_ATM];
  wire tx_output_enable   = ctrl[utxf_pkg::CTRL_OE];
  wire iso_mode           = ctrl[utxf_pkg::CTRL_ISO];
  wire ctl_endpoint       = ctrl[utxf_pkg::CTRL_CTLEP];
  wire active             = tx_endpoint_enable & auto_tx_management;

  // APB decode; the slave answers in the access cycle with no wait state.
  wire acc       = psel & penable;
  wire wr        = acc & pwrite;
  wire wr_ctrl   = wr & (paddr == utxf_pkg::OFS_CTRL);
  wire wr_clear  = wr & (paddr == utxf_pkg::OFS_CLEAR);
  wire byte_count_write = wr & (paddr == utxf_pkg::OFS_COUNT);
  wire mapped    = (paddr == utxf_pkg::OFS_CTRL) | (paddr == utxf_pkg::OFS_STATUS) |
                   (paddr == utxf_pkg::OFS_CLEAR) | (paddr == utxf_pkg::OFS_COUNT);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  wire clr_err  = wr_clear & pwdata[utxf_pkg::ST_ERR];
  wire clr_ack  = wr_clear & pwdata[utxf_pkg::ST_ACK];
  wire clr_void = wr_clear & pwdata[utxf_pkg::ST_VOID];
  wire clr_ovf  = wr_clear & pwdata[utxf_pkg::ST_OVF];
  wire clr_urf  = wr_clear & pwdata[utxf_pkg::ST_URF];
  wire clr_sof  = wr_clear & pwdata[utxf_pkg::ST_SOF];

  wire setup_received_flag = sie_evt.setup_rcvd;
  wire tx_stall_bit        = ctrl[utxf_pkg::CTRL_STALL];
  wire fill_empty = (tx_fifo_fill_state == utxf_pkg::FILL_EMPTY);
  wire fill_two   = (tx_fifo_fill_state == utxf_pkg::FILL_TWO);
  // Effective fill for iso: the deferred decrement is still counted.
  wire in_tok     = active & sie_evt.in_token;

  // Non-isochronous answer selection.
  wire ni_setup_nak = ctl_endpoint & setup_received_flag;
  wire ni_void      = fill_empty | ~tx_output_enable;
  wire ni_err_nak   = flg.urf & flg.err;
  wire ni_nak       = ni_void | ni_setup_nak | nak_lock | flg.ovf | ni_err_nak;
  // The stall bit is honoured only when no NAK condition applies.
  wire ni_stall     = tx_stall_bit & ~ni_nak;
  // Isochronous answer: a pending decrement means the slot is already spent.
  wire iso_void     = fill_empty | ~tx_output_enable | flg.urf | pend_dec;

  always_comb begin
    in_resp = utxf_pkg::RESP_NONE;
    if (in_tok) begin
      if (iso_mode) begin
        in_resp = iso_void ? utxf_pkg::RESP_NULL : utxf_pkg::RESP_DATA;
      end else if (ni_nak | ni_stall) begin
        in_resp = utxf_pkg::RESP_NAK;
      end else begin
        in_resp = utxf_pkg::RESP_DATA;
      end
    end
  end

  // Transfer outcomes, only meaningful after a data answer.
  wire done_ack = active & sie_evt.sent_ack & ~fill_empty;
  wire done_to  = active & sie_evt.sent_timeout & ~fill_empty;
  wire done_ur  = active & sie_evt.sent_underrun & ~fill_empty;
  wire ni_ack   = ~iso_mode & done_ack;
  wire ni_fail  = ~iso_mode & (done_to | done_ur);
  wire iso_done = iso_mode & (done_ack | done_to | done_ur) & ~pend_dec;
  wire sof      = active & iso_mode & sie_evt.sof;
  wire sof_flush = sof & ~pend_dec & ~fill_empty;
  wire dec_now   = ni_ack | (sof & (pend_dec | sof_flush));

  // Fill state: a packet removed and one added together leaves the count.
  wire inc_ok = active & byte_count_write & ~fill_two & ~flg.ovf;
  logic [1:0] next_fill;
  always_comb begin
    next_fill = tx_fifo_fill_state;
    if (inc_ok & ~dec_now) begin
      next_fill = fill_empty ? (rd_slot ? utxf_pkg::FILL_ONE_B
                                        : utxf_pkg::FILL_ONE_A)
                             : utxf_pkg::FILL_TWO;
    end else if (inc_ok & dec_now & ~fill_empty) begin
      next_fill = ~tx_fifo_fill_state;
    end else if (dec_now & ~inc_ok) begin
      if (fill_two) begin
        next_fill = rd_slot ? utxf_pkg::FILL_ONE_A : utxf_pkg::FILL_ONE_B;
      end else begin
        next_fill = utxf_pkg::FILL_EMPTY;
      end
    end
  end

  wire set_ovf = active & byte_count_write & fill_two;
  wire set_void = in_tok & (iso_mode ? iso_void : ni_nak);
  wire lock_set = in_tok & ~iso_mode & ~fill_empty &
                  (ni_setup_nak | ~tx_output_enable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl               <= utxf_pkg::CTRL_RESET;
      tx_fifo_fill_state <= utxf_pkg::FILL_RESET;
      rd_slot            <= 1'b0;
      tx_byte_count      <= '0;
      nak_lock           <= 1'b0;
      pend_dec           <= 1'b0;
      pend_urf           <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= pwdata[5:0];
      end
      if (inc_ok) begin
        tx_byte_count <= pwdata[utxf_pkg::COUNT_W-1:0];
      end
      tx_fifo_fill_state <= next_fill;
      if (dec_now) begin
        rd_slot <= ~rd_slot;
      end
      // Lock is released when firmware clears void, i.e. re-arms the endpoint.
      if (lock_set) begin
        nak_lock <= 1'b1;
      end else if (clr_void | ~active) begin
        nak_lock <= 1'b0;
      end
      if (iso_done) begin
        pend_dec <= 1'b1;
      end else if (sof) begin
        pend_dec <= 1'b0;
      end
      if (iso_done & done_ur) begin
        pend_urf <= 1'b1;
      end else if (sof) begin
        pend_urf <= 1'b0;
      end
    end
  end

  // Status flags; a hardware set wins over a firmware clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flg      <= '0;
      sof_flag <= 1'b0;
    end else begin
      if (ni_fail | (iso_done & done_ur)) begin
        flg.err <= 1'b1;
      end else if (ni_ack | iso_done | clr_err) begin
        flg.err <= 1'b0;
      end
      if (ni_ack | (iso_done & ~done_ur)) begin
        flg.ack <= 1'b1;
      end else if (ni_fail | iso_done | clr_ack) begin
        flg.ack <= 1'b0;
      end
      if (set_void) begin
        flg.void_f <= 1'b1;
      end else if (ni_ack | ni_fail | iso_done | clr_void) begin
        flg.void_f <= 1'b0;
      end
      if (set_ovf) begin
        flg.ovf <= 1'b1;
      end else if (clr_ovf) begin
        flg.ovf <= 1'b0;
      end
      if ((~iso_mode & done_ur) | (sof & pend_urf)) begin
        flg.urf <= 1'b1;
      end else if (clr_urf) begin
        flg.urf <= 1'b0;
      end
      if (sof_flush) begin
        sof_flag <= 1'b1;
      end else if (clr_sof) begin
        sof_flag <= 1'b0;
      end
    end
  end

  // Interrupt pulses for one cycle on every non-iso completion only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= ni_ack | ni_fail;
    end
  end

  wire [31:0] status_word = {18'h00000, tx_byte_count[3:0], tx_fifo_fill_state,
                             2'h0, sof_flag, flg.urf, flg.ovf, flg.void_f,
                             flg.ack, flg.err};
  wire [31:0] rd_mux = (paddr == utxf_pkg::OFS_CTRL)   ? {26'h0000000, ctrl} :
                       (paddr == utxf_pkg::OFS_STATUS) ? status_word :
                       (paddr == utxf_pkg::OFS_COUNT)  ?
                         {22'h000000, tx_byte_count} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  chk_ovf_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    flg.ovf & ~clr_ovf |=> flg.ovf)
    else $error("overrun flag dropped");
  chk_full_write: assert property (@(posedge pclk) disable iff (!presetn)
    active & byte_count_write & fill_two & ~dec_now |=> flg.ovf & fill_two)
    else $error("overrun not set on full");
  chk_empty_nak: assert property (@(posedge pclk) disable iff (!presetn)
    in_tok & ~iso_mode & fill_empty |-> in_resp == utxf_pkg::RESP_NAK ##1 flg.void_f)
    else $error("empty endpoint not NAKed");
  chk_void_nak: assert property (@(posedge pclk) disable iff (!presetn)
    in_tok & ~iso_mode & ~tx_output_enable |-> in_resp == utxf_pkg::RESP_NAK)
    else $error("disabled output not NAKed");
  chk_setup_nak: assert property (@(posedge pclk) disable iff (!presetn)
    in_tok & ~iso_mode & ni_setup_nak |-> in_resp == utxf_pkg::RESP_NAK ##1 flg.void_f)
    else $error("setup phase not NAKed");
  chk_stall_nak: assert property (@(posedge pclk) disable iff (!presetn)
    in_tok & ~iso_mode & tx_stall_bit |-> in_resp == utxf_pkg::RESP_NAK)
    else $error("stalled endpoint not NAKed");
  chk_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
    in_tok & ~iso_mode & nak_lock |-> in_resp == utxf_pkg::RESP_NAK)
    else $error("locked endpoint not NAKed");
  chk_fill_from_empty: assert property (@(posedge pclk) disable iff (!presetn)
    inc_ok & ~dec_now & fill_empty |=> ^tx_fifo_fill_state)
    else $error("first packet not counted");
  chk_fill_to_two: assert property (@(posedge pclk) disable iff (!presetn)
    inc_ok & ~dec_now & ~fill_empty |=> fill_two)
    else $error("second packet not counted");
  chk_ovf_nak: assert property (@(posedge pclk) disable iff (!presetn)
    in_tok & ~iso_mode & flg.ovf |-> in_resp == utxf_pkg::RESP_NAK)
    else $error("overrun endpoint not NAKed");
  chk_ovf_keep: assert property (@(posedge pclk) disable iff (!presetn)
    set_ovf & ~dec_now |=> $stable(tx_fifo_fill_state))
    else $error("overrun changed fill");
  chk_ack_irq: assert property (@(posedge pclk) disable iff (!presetn)
    ni_ack |=> tx_irq & flg.ack & ~flg.err)
    else $error("ack not reported");
  chk_ack_drop: assert property (@(posedge pclk) disable iff (!presetn)
    ni_ack & ~inc_ok & ~fill_two |=> fill_empty)
    else $error("acked packet not dropped");
  chk_timeout_keep: assert property (@(posedge pclk) disable iff (!presetn)
    ni_fail & ~inc_ok |=> $stable(tx_fifo_fill_state) && flg.err)
    else $error("timeout changed fill");
  chk_fail_irq: assert property (@(posedge pclk) disable iff (!presetn)
    ni_fail |=> tx_irq & flg.err & ~flg.ack)
    else $error("failure not reported");
  chk_urf_set: assert property (@(posedge pclk) disable iff (!presetn)
    ~iso_mode & done_ur |=> flg.urf & flg.err)
    else $error("underrun not flagged");
  chk_err_nak: assert property (@(posedge pclk) disable iff (!presetn)
    in_tok & ~iso_mode & flg.urf & flg.err |-> in_resp == utxf_pkg::RESP_NAK ##1 flg.void_f)
    else $error("underrun endpoint not NAKed");
  chk_retry_ack: assert property (@(posedge pclk) disable iff (!presetn)
    ni_ack & flg.err & ~flg.urf |=> tx_irq & flg.ack & ~flg.err)
    else $error("retry ack not reported");
  chk_urf_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    flg.urf & ~clr_urf |=> flg.urf)
    else $error("underrun flag dropped");
  chk_iso_void: assert property (@(posedge pclk) disable iff (!presetn)
    in_tok & iso_mode & fill_empty |-> in_resp == utxf_pkg::RESP_NULL ##1 flg.void_f)
    else $error("iso empty not null");
  chk_iso_no_nak: assert property (@(posedge pclk) disable iff (!presetn)
    in_tok & iso_mode |-> in_resp != utxf_pkg::RESP_NAK)
    else $error("iso answered NAK");
  chk_iso_null_oe: assert property (@(posedge pclk) disable iff (!presetn)
    in_tok & iso_mode & ~tx_output_enable |-> in_resp == utxf_pkg::RESP_NULL)
    else $error("iso disabled not null");
  chk_iso_ack: assert property (@(posedge pclk) disable iff (!presetn)
    iso_done & ~done_ur |=> flg.ack & ~flg.err & pend_dec)
    else $error("iso send not acked");
  chk_iso_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
    iso_mode & $past(iso_mode) |-> ~tx_irq)
    else $error("iso raised interrupt");
  chk_iso_urf: assert property (@(posedge pclk) disable iff (!presetn)
    iso_done & done_ur |=> flg.err & ~flg.ack & pend_dec)
    else $error("iso underrun not handled");
  chk_iso_defer: assert property (@(posedge pclk) disable iff (!presetn)
    iso_done & ~sof & ~inc_ok |=> $stable(tx_fifo_fill_state))
    else $error("iso decrement not deferred");
  chk_urf_defer: assert property (@(posedge pclk) disable iff (!presetn)
    iso_done & done_ur & ~sof & ~flg.urf |=> ~flg.urf)
    else $error("iso underrun not deferred");
  chk_iso_flags: assert property (@(posedge pclk) disable iff (!presetn)
    iso_done & ~in_tok |=> ~flg.void_f)
    else $error("iso void not cleared");
  chk_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    ~active |-> in_resp == utxf_pkg::RESP_NONE)
    else $error("answered while disabled");
  chk_fill_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ~active |=> $stable(tx_fifo_fill_state))
    else $error("fill moved while disabled");
  chk_frame_flush: assert property (@(posedge pclk) disable iff (!presetn)
    sof_flush |=> sof_flag)
    else $error("flush not flagged");
  chk_slot_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    dec_now |=> $changed(rd_slot))
    else $error("read slot not toggled");

endmodule : utxf_endpoint

// ---- bench/utxf_host_model.sv ----
`timescale 1ns/10ps
module utxf_host_model (
  // Clock and answer
  input  wire logic                 pclk,
  input  wire utxf_pkg::utxf_resp_e in_resp,
  // Events toward the endpoint
  output utxf_pkg::utxf_sie_s       sie_evt
);
  utxf_pkg::utxf_resp_e last_resp;

  initial sie_evt = '0;

  // The answer is taken at the edge that closes the token cycle.
  always @(posedge pclk) begin
    if (sie_evt.in_token === 1'b1) last_resp <= in_resp;
  end

  // Kind 0 sends no completion, 1 host ACK, 2 time-out, 3 underrun.
  // A completion only ever follows a data answer, as a real engine would.
  task automatic in_xfer(input logic [1:0] kind, output utxf_pkg::utxf_resp_e r);
    sie_evt.in_token <= 1'b1;
    @(posedge pclk);
    sie_evt.in_token <= 1'b0;
    @(posedge pclk);
    r = last_resp;
    if (r === utxf_pkg::RESP_DATA && kind != 2'h0) begin
      sie_evt[4:2] <= 3'h4 >> (kind - 2'h1);
      @(posedge pclk);
      sie_evt[4:2] <= 3'h0;
    end
    @(posedge pclk);
  endtask : in_xfer

  task automatic sof_pulse;
    sie_evt.sof <= 1'b1;
    @(posedge pclk);
    sie_evt.sof <= 1'b0;
    @(posedge pclk);
  endtask : sof_pulse

  task automatic setup_level(input logic v);
    sie_evt.setup_rcvd <= v;
    @(posedge pclk);
  endtask : setup_level
endmodule : utxf_host_model

// ---- bench/tb.sv ----
`timescale 1ns/10ps
module tb;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_slot, tx_irq;
  logic                 errs;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [31:0]          nirq = 32'h0;
  logic [1:0]           fill;
  utxf_pkg::utxf_sie_s  sie_evt;
  utxf_pkg::utxf_resp_e in_resp, r;
  int                   miscompares = 0;
  int                   comparisons = 0;
  localparam logic [31:0] EN = 32'h3;
  localparam logic [31:0] OE = 32'h4;
  localparam logic [31:0] ISO = 32'h8;

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  utxf_endpoint u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sie_evt, .in_resp, .rd_slot, .tx_irq, .tx_fifo_fill_state(fill));
  utxf_host_model u_host (.pclk, .in_resp, .sie_evt);

  always @(posedge pclk) begin
    if (tx_irq === 1'b1) nirq <= nirq + 32'h1;
  end

  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    errs = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic st(input logic [31:0] e);
    apb(1'b0, utxf_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h3F, e);
  endtask : st

  // Packet count from the fill code, so either single-packet slot is accepted.
  task automatic pk(input logic [31:0] n);
    chk({30'h0, &fill, ^fill}, n);
  endtask : pk

  task automatic tin(input logic [1:0] kind, input utxf_pkg::utxf_resp_e e);
    u_host.in_xfer(kind, r);
    chk({30'h0, r}, {30'h0, e});
  endtask : tin

  task automatic ctl(input logic [31:0] v);
    apb(1'b1, utxf_pkg::OFS_CTRL, v);
  endtask : ctl

  task automatic clr;
    apb(1'b1, utxf_pkg::OFS_CLEAR, 32'h3F);
  endtask : clr

  task automatic ld;
    apb(1'b1, utxf_pkg::OFS_COUNT, 32'h8);
  endtask : ld

  initial begin
    #100000;
    miscompares++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, utxf_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    st(32'h0);
    pk(32'h0);
    ctl(EN | OE);
    tin(2'h0, utxf_pkg::RESP_NAK);
    st(32'h4);
    clr();
    pk(32'h0);
    ld();
    chk({30'h0, fill}, 32'h1);
    ld();
    pk(32'h2);
    ld();
    st(32'h8);
    pk(32'h2);
    tin(2'h1, utxf_pkg::RESP_NAK);
    st(32'hC);
    clr();
    tin(2'h1, utxf_pkg::RESP_DATA);
    st(32'h2);
    pk(32'h1);
    chk({31'h0, rd_slot}, 32'h1);
    chk(nirq, 32'h1);
    tin(2'h2, utxf_pkg::RESP_DATA);
    st(32'h1);
    pk(32'h1);
    chk(nirq, 32'h2);
    tin(2'h1, utxf_pkg::RESP_DATA);
    st(32'h2);
    pk(32'h0);
    chk(nirq, 32'h3);
    ld();
    tin(2'h3, utxf_pkg::RESP_DATA);
    st(32'h11);
    chk(nirq, 32'h4);
    tin(2'h0, utxf_pkg::RESP_NAK);
    st(32'h15);
    pk(32'h1);
    clr();
    ctl(EN);
    tin(2'h0, utxf_pkg::RESP_NAK);
    ctl(EN | OE);
    tin(2'h0, utxf_pkg::RESP_NAK);
    clr();
    tin(2'h1, utxf_pkg::RESP_DATA);
    ctl(EN | OE | 32'h30);
    u_host.setup_level(1'b1);
    ld();
    tin(2'h0, utxf_pkg::RESP_NAK);
    st(32'h6);
    u_host.setup_level(1'b0);
    clr();
    tin(2'h0, utxf_pkg::RESP_NAK);
    ctl(32'h6);
    tin(2'h0, utxf_pkg::RESP_NONE);
    st(32'h0);
    ctl(EN | OE | ISO);
    tin(2'h1, utxf_pkg::RESP_DATA);
    st(32'h2);
    chk(nirq, 32'h5);
    pk(32'h1);
    u_host.sof_pulse();
    pk(32'h0);
    tin(2'h0, utxf_pkg::RESP_NULL);
    st(32'h6);
    clr();
    ld();
    pk(32'h1);
    ctl(EN | ISO);
    tin(2'h0, utxf_pkg::RESP_NULL);
    st(32'h4);
    ctl(EN | OE | ISO);
    u_host.sof_pulse();
    pk(32'h0);
    clr();
    ld();
    tin(2'h3, utxf_pkg::RESP_DATA);
    st(32'h1);
    u_host.sof_pulse();
    st(32'h11);
    pk(32'h0);
    clr();
    ld();
    u_host.sof_pulse();
    pk(32'h0);
    st(32'h20);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, errs}, 32'h1);
    chk(rd, 32'h0);
    end_sim();
  end
endmodule : tb
